// ==== design/ifd_pkg.sv ====
// Constants, types and helper functions for the instruction format decoder.
package ifd_pkg;

	localparam int unsigned WORD_W      = 14;
	localparam int unsigned ADDR_W      = 7;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned LIT8_W      = 8;
	localparam int unsigned LIT11_W     = 11;
	localparam int unsigned BITNUM_W    = 3;

	// Oscillator periods in one instruction cycle and the phase counter layout.
	localparam int unsigned OSC_PER_CYCLE = 4;
	localparam logic [1:0]  PHASE_FIRST   = 2'h0;
	localparam logic [1:0]  PHASE_EXEC    = 2'(OSC_PER_CYCLE - 2);
	localparam logic [1:0]  PHASE_LAST    = 2'(OSC_PER_CYCLE - 1);

	// Field positions inside the instruction word.
	localparam int unsigned CLASS_HI    = 13;
	localparam int unsigned CLASS_LO    = 12;
	localparam int unsigned DEST_POS    = 7;
	localparam int unsigned BITNUM_LO   = 7;
	localparam int unsigned ADDR_LO     = 0;

	// Special file locations: the program counter low byte and the port window.
	localparam logic [6:0]  PC_LOW_ADDR  = 7'h02;
	localparam logic [6:0]  PORT_FIRST   = 7'h05;
	localparam logic [6:0]  PORT_LAST    = 7'h09;

	// Values after reset.
	localparam logic [13:0] WORD_RESET  = 14'h0000;
	localparam logic        FLUSH_RESET = 1'b1;

	typedef enum logic [1:0] {
		CLASS_BYTE,
		CLASS_BIT,
		CLASS_LITCTL
	} ifd_class_e;

	typedef enum logic [5:0] {
		OP_NOP, OP_MOVE_W_TO_F, OP_CLEAR_W, OP_CLEAR_F, OP_SUB_WF, OP_DEC_F,
		OP_OR_WF, OP_AND_WF, OP_XOR_WF, OP_ADD_WF, OP_MOVE_F, OP_COMPL_F,
		OP_INC_F, OP_DEC_SKIP_Z, OP_ROT_RIGHT, OP_ROT_LEFT, OP_SWAP_NIB,
		OP_INC_SKIP_Z, OP_CLEAR_BIT, OP_SET_BIT, OP_SKIP_BIT_CLEAR,
		OP_SKIP_BIT_SET, OP_CALL, OP_JUMP, OP_RETURN, OP_RET_IRQ, OP_RET_LIT,
		OP_SLEEP, OP_CLEAR_WDOG, OP_MOVE_LIT, OP_OR_LIT, OP_AND_LIT,
		OP_XOR_LIT, OP_SUB_LIT, OP_ADD_LIT
	} ifd_op_e;

	// One-hot mask of the selected bit inside a file register.
	function automatic logic [7:0] bit_mask(input logic [2:0] num);
		bit_mask = 8'h01 << num;
	endfunction : bit_mask

	// True when a file address falls inside the port register window.
	function automatic logic is_port(input logic [6:0] addr);
		is_port = (addr >= PORT_FIRST) && (addr <= PORT_LAST);
	endfunction : is_port

endpackage : ifd_pkg

// ==== design/ifd_fields_if.sv ====
// Interface carrying one instruction word and its decoded fields.
`timescale 1ns/10ps
interface ifd_fields_if;
	logic [13:0]        word;
	ifd_pkg::ifd_class_e cls;
	ifd_pkg::ifd_op_e    op;
	logic [6:0]         file_addr;
	logic               dest_file;
	logic [2:0]         bit_num;
	logic [7:0]         lit8;
	logic [10:0]        lit11;
	logic               writes_w;
	logic               writes_f;
	logic               sets_status;
	logic               is_branch;

	modport split (input word, output cls, op, file_addr, dest_file, bit_num, lit8, lit11,
		writes_w, writes_f, sets_status, is_branch);
	modport core (output word, input cls, op, file_addr, dest_file, bit_num, lit8, lit11,
		writes_w, writes_f, sets_status, is_branch);
endinterface : ifd_fields_if

// ==== design/ifd_field_split.sv ====
// Splits a 14-bit instruction word into its class, operation and operand fields.
`timescale 1ns/10ps
module ifd_field_split (
	// Word in, fields out.
	ifd_fields_if.split f
);

	logic [13:0] w;
	logic        d;

	assign w = f.word;
	assign d = w[ifd_pkg::DEST_POS];

	always_comb begin
		f.cls       = ifd_pkg::CLASS_LITCTL;
		unique case (w[ifd_pkg::CLASS_HI:ifd_pkg::CLASS_LO])
			2'h0: f.cls = ifd_pkg::CLASS_BYTE;
			2'h1: f.cls = ifd_pkg::CLASS_BIT;
			default: f.cls = ifd_pkg::CLASS_LITCTL;
		endcase
		f.file_addr = w[ifd_pkg::ADDR_LO +: ifd_pkg::ADDR_W];
		f.dest_file = d;
		f.bit_num   = w[ifd_pkg::BITNUM_LO +: ifd_pkg::BITNUM_W];
		f.lit8      = w[0 +: ifd_pkg::LIT8_W];
		f.lit11     = w[0 +: ifd_pkg::LIT11_W];
		// Unlisted and retired encodings decode as no-operation.
		f.op        = ifd_pkg::OP_NOP;
		// Wildcards stand on every don't-care bit so either value decodes alike.
		casez (w)
			14'b00_0000_0000_1000: f.op = ifd_pkg::OP_RETURN;
			14'b00_0000_0000_1001: f.op = ifd_pkg::OP_RET_IRQ;
			14'b00_0000_0110_0011: f.op = ifd_pkg::OP_SLEEP;
			14'b00_0000_0110_0100: f.op = ifd_pkg::OP_CLEAR_WDOG;
			14'b00_0000_1???_????: f.op = ifd_pkg::OP_MOVE_W_TO_F;
			14'b00_0001_0???_????: f.op = ifd_pkg::OP_CLEAR_W;
			14'b00_0001_1???_????: f.op = ifd_pkg::OP_CLEAR_F;
			14'b00_0010_????_????: f.op = ifd_pkg::OP_SUB_WF;
			14'b00_0011_????_????: f.op = ifd_pkg::OP_DEC_F;
			14'b00_0100_????_????: f.op = ifd_pkg::OP_OR_WF;
			14'b00_0101_????_????: f.op = ifd_pkg::OP_AND_WF;
			14'b00_0110_????_????: f.op = ifd_pkg::OP_XOR_WF;
			14'b00_0111_????_????: f.op = ifd_pkg::OP_ADD_WF;
			14'b00_1000_????_????: f.op = ifd_pkg::OP_MOVE_F;
			14'b00_1001_????_????: f.op = ifd_pkg::OP_COMPL_F;
			14'b00_1010_????_????: f.op = ifd_pkg::OP_INC_F;
			14'b00_1011_????_????: f.op = ifd_pkg::OP_DEC_SKIP_Z;
			14'b00_1100_????_????: f.op = ifd_pkg::OP_ROT_RIGHT;
			14'b00_1101_????_????: f.op = ifd_pkg::OP_ROT_LEFT;
			14'b00_1110_????_????: f.op = ifd_pkg::OP_SWAP_NIB;
			14'b00_1111_????_????: f.op = ifd_pkg::OP_INC_SKIP_Z;
			14'b01_00??_????_????: f.op = ifd_pkg::OP_CLEAR_BIT;
			14'b01_01??_????_????: f.op = ifd_pkg::OP_SET_BIT;
			14'b01_10??_????_????: f.op = ifd_pkg::OP_SKIP_BIT_CLEAR;
			14'b01_11??_????_????: f.op = ifd_pkg::OP_SKIP_BIT_SET;
			14'b10_0???_????_????: f.op = ifd_pkg::OP_CALL;
			14'b10_1???_????_????: f.op = ifd_pkg::OP_JUMP;
			14'b11_00??_????_????: f.op = ifd_pkg::OP_MOVE_LIT;
			14'b11_01??_????_????: f.op = ifd_pkg::OP_RET_LIT;
			14'b11_1000_????_????: f.op = ifd_pkg::OP_OR_LIT;
			14'b11_1001_????_????: f.op = ifd_pkg::OP_AND_LIT;
			14'b11_1010_????_????: f.op = ifd_pkg::OP_XOR_LIT;
			14'b11_110?_????_????: f.op = ifd_pkg::OP_SUB_LIT;
			14'b11_111?_????_????: f.op = ifd_pkg::OP_ADD_LIT;
			default: f.op = ifd_pkg::OP_NOP;
		endcase
		// Return, sleep and watchdog clear share the zero prefix but are control words.
		if (f.op == ifd_pkg::OP_RETURN || f.op == ifd_pkg::OP_RET_IRQ
			|| f.op == ifd_pkg::OP_SLEEP || f.op == ifd_pkg::OP_CLEAR_WDOG) begin
			f.cls = ifd_pkg::CLASS_LITCTL;
		end
		f.writes_w    = 1'b0;
		f.writes_f    = 1'b0;
		f.sets_status = 1'b0;
		f.is_branch   = 1'b0;
		unique case (f.op)
			ifd_pkg::OP_MOVE_W_TO_F, ifd_pkg::OP_CLEAR_BIT, ifd_pkg::OP_SET_BIT: begin
				f.writes_f = 1'b1;
			end
			ifd_pkg::OP_CLEAR_F: begin
				f.writes_f    = 1'b1;
				f.sets_status = 1'b1;
			end
			ifd_pkg::OP_SUB_WF, ifd_pkg::OP_DEC_F, ifd_pkg::OP_OR_WF, ifd_pkg::OP_AND_WF,
			ifd_pkg::OP_XOR_WF, ifd_pkg::OP_ADD_WF, ifd_pkg::OP_MOVE_F, ifd_pkg::OP_COMPL_F,
			ifd_pkg::OP_INC_F, ifd_pkg::OP_ROT_RIGHT, ifd_pkg::OP_ROT_LEFT: begin
				f.writes_w    = !d;
				f.writes_f    = d;
				f.sets_status = 1'b1;
			end
			ifd_pkg::OP_SWAP_NIB, ifd_pkg::OP_DEC_SKIP_Z, ifd_pkg::OP_INC_SKIP_Z: begin
				f.writes_w = !d;
				f.writes_f = d;
			end
			ifd_pkg::OP_CLEAR_W, ifd_pkg::OP_OR_LIT, ifd_pkg::OP_AND_LIT,
			ifd_pkg::OP_XOR_LIT, ifd_pkg::OP_SUB_LIT, ifd_pkg::OP_ADD_LIT: begin
				f.writes_w    = 1'b1;
				f.sets_status = 1'b1;
			end
			ifd_pkg::OP_MOVE_LIT: begin
				f.writes_w = 1'b1;
			end
			ifd_pkg::OP_RET_LIT: begin
				f.writes_w  = 1'b1;
				f.is_branch = 1'b1;
			end
			ifd_pkg::OP_CALL, ifd_pkg::OP_JUMP, ifd_pkg::OP_RETURN, ifd_pkg::OP_RET_IRQ: begin
				f.is_branch = 1'b1;
			end
			ifd_pkg::OP_SLEEP, ifd_pkg::OP_CLEAR_WDOG: begin
				f.sets_status = 1'b1;
			end
			default: begin
				f.writes_w = 1'b0;
			end
		endcase
	end

endmodule : ifd_field_split

// ==== design/ifd_core.sv ====
// Instruction cycle sequencer and decode register stage of the core.
`timescale 1ns/10ps
module ifd_core (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Program memory word, valid on the edge that ends the last phase.
	input  wire logic [13:0]         instr_word,
	// Execution feedback sampled at the end of the execute phase.
	input  wire logic [7:0]          file_rd_data,
	input  wire logic                alu_zero,
	// Cycle timing.
	output logic [1:0]               phase,
	output logic                     fetch_strobe,
	output logic                     nop_cycle,
	// Decoded fields of the executing word.
	output ifd_pkg::ifd_class_e      instr_class,
	output ifd_pkg::ifd_op_e         op,
	output logic [6:0]               file_addr,
	output logic                     dest_file,
	output logic [2:0]               bit_num,
	output logic [7:0]               bit_mask,
	output logic [7:0]               literal8,
	output logic [10:0]              literal11,
	output logic                     read_pins,
	// Write strobes and redirection, one clock in the last phase.
	output logic                     w_write,
	output logic                     f_write,
	output logic                     status_write,
	output logic                     pc_redirect
);

	// The field split works on the word as it stands on the memory bus.
	ifd_fields_if fld ();

	ifd_field_split u_split (
		.f (fld.split)
	);

	assign fld.word = instr_word;

	// Phase counter: four oscillator periods make one instruction cycle.
	logic [1:0] phase_r;
	logic [1:0] phase_nxt;

	always_comb begin
		phase_nxt = (phase_r == ifd_pkg::PHASE_LAST) ? ifd_pkg::PHASE_FIRST
			: 2'(phase_r + 2'h1);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= ifd_pkg::PHASE_FIRST;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// Decode stage: fields latched once per cycle as the new word arrives.
	ifd_pkg::ifd_class_e cls_r, cls_nxt;
	ifd_pkg::ifd_op_e    op_r, op_nxt;
	logic [6:0]  addr_r, addr_nxt;
	logic        dest_r, dest_nxt;
	logic [2:0]  bnum_r, bnum_nxt;
	logic [7:0]  mask_r, mask_nxt;
	logic [7:0]  lit8_r, lit8_nxt;
	logic [10:0] lit11_r, lit11_nxt;
	logic        ww_r, ww_nxt;
	logic        wf_r, wf_nxt;
	logic        st_r, st_nxt;
	logic        br_r, br_nxt;
	logic        pins_r, pins_nxt;
	logic        flush_r, flush_nxt;
	logic        taken_r, taken_nxt;

	always_comb begin
		// Every field holds by default; only the last phase loads new ones.
		cls_nxt   = cls_r;
		op_nxt    = op_r;
		addr_nxt  = addr_r;
		dest_nxt  = dest_r;
		bnum_nxt  = bnum_r;
		mask_nxt  = mask_r;
		lit8_nxt  = lit8_r;
		lit11_nxt = lit11_r;
		ww_nxt    = ww_r;
		wf_nxt    = wf_r;
		st_nxt    = st_r;
		br_nxt    = br_r;
		pins_nxt  = pins_r;
		flush_nxt = flush_r;
		// Fields change only as a new word is taken, so they stand for a whole cycle.
		if (phase_r == ifd_pkg::PHASE_LAST) begin
			cls_nxt   = fld.cls;
			op_nxt    = fld.op;
			addr_nxt  = fld.file_addr;
			dest_nxt  = fld.dest_file;
			bnum_nxt  = fld.bit_num;
			mask_nxt  = ifd_pkg::bit_mask(fld.bit_num);
			lit8_nxt  = fld.lit8;
			lit11_nxt = fld.lit11;
			ww_nxt    = fld.writes_w;
			wf_nxt    = fld.writes_f;
			st_nxt    = fld.sets_status;
			// A write of the program counter low byte also changes the flow.
			br_nxt    = fld.is_branch
				|| (fld.writes_f && fld.file_addr == ifd_pkg::PC_LOW_ADDR);
			// Read-modify-write of a port register must see the pin levels.
			pins_nxt  = fld.writes_f && fld.op != ifd_pkg::OP_MOVE_W_TO_F
				&& fld.op != ifd_pkg::OP_CLEAR_F
				&& ifd_pkg::is_port(fld.file_addr);
			// The word after a taken skip or branch runs as a no-operation.
			flush_nxt = taken_r;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cls_r   <= ifd_pkg::CLASS_BYTE;
			op_r    <= ifd_pkg::OP_NOP;
			addr_r  <= '0;
			dest_r  <= 1'b0;
			bnum_r  <= '0;
			mask_r  <= '0;
			lit8_r  <= '0;
			lit11_r <= '0;
			ww_r    <= 1'b0;
			wf_r    <= 1'b0;
			st_r    <= 1'b0;
			br_r    <= 1'b0;
			pins_r  <= 1'b0;
			// The first cycle after reset runs empty while the first word is fetched.
			flush_r <= ifd_pkg::FLUSH_RESET;
		end else begin
			cls_r   <= cls_nxt;
			op_r    <= op_nxt;
			addr_r  <= addr_nxt;
			dest_r  <= dest_nxt;
			bnum_r  <= bnum_nxt;
			mask_r  <= mask_nxt;
			lit8_r  <= lit8_nxt;
			lit11_r <= lit11_nxt;
			ww_r    <= ww_nxt;
			wf_r    <= wf_nxt;
			st_r    <= st_nxt;
			br_r    <= br_nxt;
			pins_r  <= pins_nxt;
			flush_r <= flush_nxt;
		end
	end

	// Execute decision and strobes, made at the end of the execute phase.
	logic skip_true;
	logic ww_pulse_r, ww_pulse_nxt;
	logic wf_pulse_r, wf_pulse_nxt;
	logic st_pulse_r, st_pulse_nxt;
	logic redirect_r, redirect_nxt;
	logic fetch_r, fetch_nxt;

	always_comb begin
		// The skip test sees file data and the zero flag as they stand in the execute phase.
		unique case (op_r)
			ifd_pkg::OP_SKIP_BIT_CLEAR: skip_true = (file_rd_data & mask_r) == 8'h00;
			ifd_pkg::OP_SKIP_BIT_SET:   skip_true = (file_rd_data & mask_r) != 8'h00;
			ifd_pkg::OP_DEC_SKIP_Z,
			ifd_pkg::OP_INC_SKIP_Z:     skip_true = alu_zero;
			default:                    skip_true = 1'b0;
		endcase
		// Taken holds from one execute decision until the next execute phase.
		taken_nxt    = taken_r;
		ww_pulse_nxt = 1'b0;
		wf_pulse_nxt = 1'b0;
		st_pulse_nxt = 1'b0;
		redirect_nxt = 1'b0;
		// The fetch strobe leads the word latch by one clock so memory has a full period.
		fetch_nxt    = (phase_r == ifd_pkg::PHASE_EXEC);
		if (phase_r == ifd_pkg::PHASE_EXEC) begin
			// A flushed cycle neither writes nor extends itself.
			taken_nxt    = !flush_r && (br_r || skip_true);
			ww_pulse_nxt = !flush_r && ww_r;
			wf_pulse_nxt = !flush_r && wf_r;
			st_pulse_nxt = !flush_r && st_r;
			redirect_nxt = !flush_r && br_r;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			taken_r    <= 1'b0;
			ww_pulse_r <= 1'b0;
			wf_pulse_r <= 1'b0;
			st_pulse_r <= 1'b0;
			redirect_r <= 1'b0;
			fetch_r    <= 1'b0;
		end else begin
			taken_r    <= taken_nxt;
			ww_pulse_r <= ww_pulse_nxt;
			wf_pulse_r <= wf_pulse_nxt;
			st_pulse_r <= st_pulse_nxt;
			redirect_r <= redirect_nxt;
			fetch_r    <= fetch_nxt;
		end
	end

	// Every output is a register, so the consumers never see decode glitches.
	assign phase        = phase_r;
	assign fetch_strobe = fetch_r;
	assign nop_cycle    = flush_r;
	assign instr_class  = cls_r;
	assign op           = op_r;
	assign file_addr    = addr_r;
	assign dest_file    = dest_r;
	assign bit_num      = bnum_r;
	assign bit_mask     = mask_r;
	assign literal8     = lit8_r;
	assign literal11    = lit11_r;
	assign read_pins    = pins_r;
	assign w_write      = ww_pulse_r;
	assign f_write      = wf_pulse_r;
	assign status_write = st_pulse_r;
	assign pc_redirect  = redirect_r;

endmodule : ifd_core

// ==== verif/ifd_prog_mem.sv ====
// Program memory stand-in that presents the queued word while the core fetches.
`timescale 1ns/10ps
module ifd_prog_mem (
	// Fetch timing from the core.
	input  wire logic        fetch_strobe,
	// Word queued by the bench.
	input  wire logic [13:0] next_word,
	// Word bus to the core.
	output logic      [13:0] instr_word
);
	// Outside the fetch phase the bus is not driven; the inverse keeps stale data from matching.
	assign instr_word = fetch_strobe ? next_word : ~next_word;
endmodule : ifd_prog_mem

// ==== verif/ifd_core_asserts.sv ====
// Concurrent checks on the ports of the instruction decoder core.
`timescale 1ns/10ps
module ifd_core_asserts (
	// Clock and reset.
	input wire logic                clk,
	input wire logic                reset_n,
	// Observed ports.
	input wire logic [7:0]          file_rd_data,
	input wire logic                alu_zero,
	input wire logic [1:0]          phase,
	input wire logic                fetch_strobe,
	input wire logic                nop_cycle,
	input wire ifd_pkg::ifd_class_e instr_class,
	input wire ifd_pkg::ifd_op_e    op,
	input wire logic                dest_file,
	input wire logic [2:0]          bit_num,
	input wire logic [7:0]          bit_mask,
	input wire logic                w_write,
	input wire logic                f_write,
	input wire logic                status_write,
	input wire logic                pc_redirect
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic any_wr;
	logic live3;
	assign any_wr = w_write | f_write | status_write | pc_redirect;
	assign live3 = (phase == 2'h3) && !nop_cycle;
	sequence s_cycle;
		phase == 2'h0 ##1 phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3;
	endsequence
	sequence s_next_idle;
		##2 nop_cycle;
	endsequence
	sequence s_redirect_flush;
		pc_redirect ##1 nop_cycle;
	endsequence
	a_phase_count: assert property (phase == 2'h3 |=> s_cycle)
		else $error("phase count broken");
	a_fetch_last: assert property (fetch_strobe == (phase == 2'h3))
		else $error("fetch strobe out of phase");
	a_strobe_last: assert property (any_wr |-> phase == 2'h3)
		else $error("strobe outside last phase");
	a_nop_quiet: assert property (nop_cycle |-> !any_wr)
		else $error("strobe in no-operation cycle");
	a_fields_stand: assert property (
		phase != 2'h0 |-> $stable(op) && $stable(nop_cycle))
		else $error("decode changed mid cycle");
	a_dest_route: assert property (
		instr_class == ifd_pkg::CLASS_BYTE && live3 && (w_write || f_write)
		|-> f_write == dest_file && w_write == !dest_file)
		else $error("result routed against destination");
	a_mask_hot: assert property (
		instr_class == ifd_pkg::CLASS_BIT |-> bit_mask == 8'(8'h01 << bit_num))
		else $error("bit mask wrong");
	a_bit_write: assert property (
		live3 && (op == ifd_pkg::OP_CLEAR_BIT || op == ifd_pkg::OP_SET_BIT)
		|-> f_write && !w_write && !status_write)
		else $error("bit op write wrong");
	a_skip_taken: assert property (
		phase == 2'h2 && !nop_cycle && op == ifd_pkg::OP_SKIP_BIT_CLEAR
		&& (file_rd_data & bit_mask) == 8'h00 |-> s_next_idle)
		else $error("taken skip without idle cycle");
	a_skip_set: assert property (
		phase == 2'h2 && !nop_cycle && op == ifd_pkg::OP_SKIP_BIT_SET
		&& (file_rd_data & bit_mask) != 8'h00 |-> s_next_idle)
		else $error("taken bit-set skip without idle cycle");
	a_zero_skip: assert property (
		phase == 2'h2 && !nop_cycle && alu_zero
		&& (op == ifd_pkg::OP_DEC_SKIP_Z || op == ifd_pkg::OP_INC_SKIP_Z) |-> s_next_idle)
		else $error("zero skip without idle cycle");
	a_jump_nop: assert property (
		live3 && op == ifd_pkg::OP_JUMP |-> s_redirect_flush)
		else $error("jump without redirect and idle cycle");
endmodule : ifd_core_asserts

bind ifd_core ifd_core_asserts chk (
	.clk(clk), .reset_n(reset_n), .file_rd_data(file_rd_data), .alu_zero(alu_zero), .phase(phase),
	.fetch_strobe(fetch_strobe), .nop_cycle(nop_cycle), .instr_class(instr_class), .op(op),
	.dest_file(dest_file), .bit_num(bit_num), .bit_mask(bit_mask), .w_write(w_write),
	.f_write(f_write), .status_write(status_write), .pc_redirect(pc_redirect)
);

// ==== verif/tb_instruction_format_decoder.sv ====
// Self-checking bench for the instruction decoder core.
`timescale 1ns/10ps
module tb_instruction_format_decoder;
	logic                clk;
	logic                reset_n;
	logic [13:0]         instr_word;
	logic [13:0]         next_word;
	logic [13:0]         fill;
	logic [7:0]          file_rd_data;
	logic                alu_zero;
	logic [1:0]          phase;
	logic                fetch_strobe;
	logic                nop_cycle;
	ifd_pkg::ifd_class_e instr_class;
	ifd_pkg::ifd_op_e    op;
	logic [6:0]          file_addr;
	logic                dest_file;
	logic [2:0]          bit_num;
	logic [7:0]          bit_mask;
	logic [7:0]          literal8;
	logic [10:0]         literal11;
	logic                read_pins;
	logic                w_write;
	logic                f_write;
	logic                status_write;
	logic                pc_redirect;
	logic [2:0]          wrs;
	int                  mismatches;
	int                  n_checks;
	assign wrs = {w_write, f_write, status_write};

	ifd_core uut (.clk, .reset_n, .instr_word, .file_rd_data, .alu_zero, .phase, .fetch_strobe,
		.nop_cycle, .instr_class, .op, .file_addr, .dest_file, .bit_num, .bit_mask, .literal8,
		.literal11, .read_pins, .w_write, .f_write, .status_write, .pc_redirect);
	ifd_prog_mem mem (.fetch_strobe, .next_word, .instr_word);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic step_to(input logic [1:0] ph);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (phase !== ph && i < 8);
		if (phase !== ph) begin
			mismatches++;
			print_verdict();
		end
	endtask : step_to

	// Queues a word, feeds its file read data and stops in its last phase.
	task automatic exec(input logic [13:0] w, input logic [7:0] rd);
		step_to(2'h2);
		next_word = w;
		step_to(2'h0);
		next_word = fill;
		file_rd_data = rd;
		step_to(2'h3);
	endtask : exec

	task automatic t_byte();
		for (int d = 0; d < 2; d++) begin
			exec({6'h07, d[0], 7'h7F}, 8'h00);
			check("class", instr_class, ifd_pkg::CLASS_BYTE);
			check("op", op, ifd_pkg::OP_ADD_WF);
			check("addr", file_addr, 7'h7F);
			check("dest", dest_file, d[0]);
			check("writes", wrs, {!d[0], d[0], 1'b1});
		end
		exec(14'h0586, 8'h00);
		check("pins port", read_pins, 1'b1);
		exec(14'h0590, 8'h00);
		check("pins ram", read_pins, 1'b0);
	endtask : t_byte

	task automatic t_bits();
		ifd_pkg::ifd_op_e ops [4];
		ops = '{ifd_pkg::OP_CLEAR_BIT, ifd_pkg::OP_SET_BIT, ifd_pkg::OP_SKIP_BIT_CLEAR,
			ifd_pkg::OP_SKIP_BIT_SET};
		for (int s = 0; s < 4; s++) begin
			exec({2'b01, s[1:0], 3'h7, 7'h10}, (s == 3) ? 8'h80 : 8'h7F);
			check("class", instr_class, ifd_pkg::CLASS_BIT);
			check("op", op, ops[s]);
			check("bit", bit_num, 3'h7);
			check("mask", bit_mask, 8'h80);
			check("writes", wrs, (s < 2) ? 3'b010 : 3'b000);
			step_to(2'h0);
			check("idle", nop_cycle, s >= 2);
		end
		exec(14'h1810, 8'h01);
		check("mask", bit_mask, 8'h01);
		step_to(2'h0);
		check("idle", nop_cycle, 1'b0);
	endtask : t_bits

	task automatic t_lit();
		logic [13:0] words [4];
		words = '{14'h30A5, 14'h33A5, 14'h0100, 14'h017F};
		for (int i = 0; i < 4; i++) begin
			exec(words[i], 8'h00);
			check("op", op, (i < 2) ? ifd_pkg::OP_MOVE_LIT : ifd_pkg::OP_CLEAR_W);
			check("writes", wrs, (i < 2) ? 3'b100 : 3'b101);
			if (i < 2) begin
				check("lit8", literal8, 8'hA5);
				check("class", instr_class, ifd_pkg::CLASS_LITCTL);
			end
		end
		fill = 14'h0790;
		exec(14'h2FFF, 8'h00);
		fill = 14'h0000;
		check("lit11", literal11, 11'h7FF);
		check("op", op, ifd_pkg::OP_JUMP);
		check("redirect", pc_redirect, 1'b1);
		step_to(2'h0);
		check("idle", nop_cycle, 1'b1);
		step_to(2'h3);
		check("idle writes", {wrs, pc_redirect}, 4'h0);
	endtask : t_lit

	// Zero-flag skips, returns, program counter writes and words that decode as no-operation.
	task automatic t_ctl();
		logic [13:0]         words [7];
		ifd_pkg::ifd_op_e    ops [7];
		ifd_pkg::ifd_class_e cls [7];
		logic [3:0]          wr_exp [7];
		words  = '{14'h0B90, 14'h0F10, 14'h0008, 14'h0782, 14'h0063, 14'h0062, 14'h0060};
		ops    = '{ifd_pkg::OP_DEC_SKIP_Z, ifd_pkg::OP_INC_SKIP_Z, ifd_pkg::OP_RETURN,
			ifd_pkg::OP_ADD_WF, ifd_pkg::OP_SLEEP, ifd_pkg::OP_NOP, ifd_pkg::OP_NOP};
		cls    = '{ifd_pkg::CLASS_BYTE, ifd_pkg::CLASS_BYTE, ifd_pkg::CLASS_LITCTL,
			ifd_pkg::CLASS_BYTE, ifd_pkg::CLASS_LITCTL, ifd_pkg::CLASS_BYTE, ifd_pkg::CLASS_BYTE};
		wr_exp = '{4'h4, 4'h8, 4'h1, 4'h7, 4'h2, 4'h0, 4'h0};
		for (int i = 0; i < 7; i++) begin
			alu_zero = (i == 0);
			exec(words[i], 8'h00);
			check("op", op, ops[i]);
			check("class", instr_class, cls[i]);
			check("strobes", {wrs, pc_redirect}, wr_exp[i]);
			step_to(2'h0);
			check("idle", nop_cycle, wr_exp[i][0] || i == 0);
		end
		alu_zero = 1'b0;
	endtask : t_ctl

	// Reset in mid-cycle; the first word after release must still run.
	task automatic t_reset();
		step_to(2'h1);
		reset_n = 1'b0;
		@(posedge clk);
		#1;
		check("mid reset", {phase, nop_cycle, wrs, pc_redirect}, 7'h10);
		check("mid reset op", op, ifd_pkg::OP_NOP);
		reset_n = 1'b1;
		exec(14'h3E01, 8'h00);
		check("first op", op, ifd_pkg::OP_ADD_LIT);
		check("first lit", literal8, 8'h01);
		check("first writes", {wrs, pc_redirect}, 4'hA);
	endtask : t_reset

	initial begin
		mismatches = 0;
		n_checks = 0;
		reset_n = 1'b0;
		next_word = 14'h0000;
		fill = 14'h0000;
		file_rd_data = 8'h00;
		alu_zero = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		check("reset phase", phase, 2'h0);
		check("reset idle", nop_cycle, 1'b1);
		check("reset writes", {wrs, pc_redirect}, 4'h0);
		reset_n = 1'b1;
		t_byte();
		t_bits();
		t_lit();
		t_ctl();
		t_reset();
		print_verdict();
	end
endmodule : tb_instruction_format_decoder
